/* hdl/dout_chan_if.sv */
// per-output carrier from the register side to the pulse generator
// assumes both ends share clk
`timescale 1ns/100ps
interface dout_chan_if;
    import dout_pkg::*;
    out_type_t  mode;
    logic [2:0] rate;
    logic       span_wide;
    logic       pol;
    logic [6:0] pct;
    logic       tick;
    modport src (output mode, rate, span_wide, pol, pct, tick);
    modport gen (input  mode, rate, span_wide, pol, pct, tick);
endinterface : dout_chan_if

/* hdl/dout_pkg.sv */
// constants and types for the configurable digital output block
// assumes a single 25 MHz clock; time constants are kept in their own units
package dout_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ    = 25_000_000;
    localparam int unsigned TICK_US   = 10;
    localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;

    // period per rate code, in microseconds
    localparam int unsigned PERIOD_US [8] = '{10_000, 100_000, 1_000_000, 10_000_000,
                                              20_000, 30_303, 40_000, 50_000};
    localparam logic [2:0]  SERVO_FALLBACK_RATE = 3'h4;

    // servo pulse limits, in microseconds, and in ticks
    localparam int unsigned SERVO_NARROW_MIN_US = 1000;
    localparam int unsigned SERVO_NARROW_MAX_US = 2000;
    localparam int unsigned SERVO_WIDE_MIN_US   = 500;
    localparam int unsigned SERVO_WIDE_MAX_US   = 2500;
    localparam logic [19:0] SERVO_NARROW_MIN_T  = 20'(SERVO_NARROW_MIN_US / TICK_US);
    localparam logic [19:0] SERVO_NARROW_MAX_T  = 20'(SERVO_NARROW_MAX_US / TICK_US);
    localparam logic [19:0] SERVO_WIDE_MIN_T    = 20'(SERVO_WIDE_MIN_US / TICK_US);
    localparam logic [19:0] SERVO_WIDE_MAX_T    = 20'(SERVO_WIDE_MAX_US / TICK_US);

    // control word field positions
    localparam int unsigned RATE_LSB     = 0;
    localparam int unsigned POL_BIT      = 4;
    localparam int unsigned SPAN_BIT     = 5;
    localparam int unsigned TYPE_LSB     = 8;
    localparam int unsigned TRACK_BIT    = 12;
    localparam int unsigned SRC_LSB      = 13;
    localparam int unsigned SRC_EN_BIT   = 15;
    localparam logic [15:0] CFG_WMASK    = 16'hef3f;
    localparam logic [15:0] CFG_RESET    = 16'h0000;

    // full-scale percent, and percent and scale register reset values
    localparam logic [6:0]  PCT_FULL     = 7'h64;
    localparam logic [6:0]  VAL_RESET    = 7'h00;
    localparam logic [15:0] LO_RESET     = 16'h0000;
    localparam logic [15:0] HI_RESET     = 16'hffff;

    // register selectors on the write and read ports
    localparam logic [1:0]  REG_CFG      = 2'h0;
    localparam logic [1:0]  REG_VALUE    = 2'h1;
    localparam logic [1:0]  REG_SCALE_LO = 2'h2;
    localparam logic [1:0]  REG_SCALE_HI = 2'h3;

    typedef enum logic [1:0] {TYPE_NULL, TYPE_ONOFF, TYPE_PWM, TYPE_SERVO} out_type_t;

endpackage : dout_pkg

/* hdl/dout_pulse_gen.sv */
// one output line: on/off, pwm or servo pulse from a 10 us tick
// assumes the mode and percent come from registers on the same clock
`timescale 1ns/100ps
module dout_pulse_gen (
    input  wire logic clk,
    input  wire logic rstn,
    dout_chan_if.gen  ch,
    output logic      pin_out,
    output logic      pin_oe
);
    import dout_pkg::*;

    typedef struct packed {
        logic [19:0] cnt;
        logic [19:0] per;
        logic [19:0] width;
        logic        oe;
    } gen_st_t;

    gen_st_t     q;
    gen_st_t     d;
    logic [19:0] per_now;
    logic [19:0] smin;
    logic [19:0] smax;
    logic        wrap;
    logic        active;

    // period of the selected rate; servo only runs at codes 0 and 4
    always_comb begin
        logic [2:0] r;
        r = ch.rate;
        if (ch.mode == TYPE_SERVO && r != 3'h0) begin // RULE7
            r = SERVO_FALLBACK_RATE;
        end
        per_now = 20'(PERIOD_US[r] / TICK_US); // RULE5 RULE6
        smin    = ch.span_wide ? SERVO_WIDE_MIN_T : SERVO_NARROW_MIN_T; // RULE8
        smax    = ch.span_wide ? SERVO_WIDE_MAX_T : SERVO_NARROW_MAX_T;
    end

    assign wrap = ch.tick && (q.cnt >= q.per - 20'h1);

    // counter, per-period latch of width, line drive
    always_comb begin
        d = q;
        if (ch.tick) begin
            d.cnt = q.cnt + 20'h1;
        end
        if (wrap) begin
            d.cnt = 20'h0;
            d.per = per_now;
            if (ch.mode == TYPE_SERVO) begin
                d.width = smin + 20'((27'(smax - smin) * 27'(ch.pct)) / 27'd100); // RULE8 RULE16
            end else begin
                d.width = 20'((27'(per_now) * 27'(ch.pct)) / 27'd100); // RULE6
            end
        end
        unique case (ch.mode)
            TYPE_NULL:  active = 1'b0;
            TYPE_ONOFF: active = (ch.pct != 7'h0); // RULE4
            TYPE_PWM:   active = (q.cnt < q.width);
            TYPE_SERVO: active = (q.cnt < q.width);
        endcase
        // active low pulls the line, active high releases it
        d.oe = (ch.mode == TYPE_NULL) ? 1'b0 : (active ^ ch.pol); // RULE3 RULE9
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{cnt: 20'h0, per: 20'h1, width: 20'h0, oe: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pin_out = 1'b0;
    assign pin_oe  = q.oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_servo_wrap;
        ch.mode == TYPE_SERVO && wrap;
    endsequence

    sequence s_null_held;
        (ch.mode == TYPE_NULL) [*2];
    endsequence

    // full duty latched, then polarity held for one more cycle
    sequence s_full_duty;
        ch.mode == TYPE_PWM && q.width == q.per ##1 ch.mode == TYPE_PWM && $stable(ch.pol);
    endsequence

    a_null_no_drive: assert property (s_null_held |-> !pin_oe) // RULE3
        else $error("null output is driving the line");

    a_onoff_level: assert property (ch.mode == TYPE_ONOFF |=> // RULE4
        pin_oe == (($past(ch.pct) != 7'h0) ^ $past(ch.pol)))
        else $error("on/off level wrong");

    a_period_wrap: assert property (wrap |=> q.cnt == 20'h0) // RULE6
        else $error("period counter did not wrap");

    a_count_bound: assert property (q.cnt < 20'd1_000_000) // RULE5
        else $error("period counter past longest period");

    a_servo_rate: assert property (s_servo_wrap |=> // RULE7
        (q.per == 20'd1000 || q.per == 20'd2000))
        else $error("servo period not 10 or 20 ms");

    a_servo_span: assert property (s_servo_wrap |=> // RULE8
        q.width >= ($past(ch.span_wide) ? 20'd50 : 20'd100) &&
        q.width <= ($past(ch.span_wide) ? 20'd250 : 20'd200))
        else $error("servo pulse outside span");

    a_pol_drive: assert property (s_full_duty |-> pin_oe == !ch.pol) // RULE9
        else $error("full duty drive level wrong");

endmodule : dout_pulse_gen

/* hdl/dout_top.sv */
// configurable digital outputs: control words, percent values, sensor tracking
// assumes sensor readings and register strobes come from logic on clk
`timescale 1ns/100ps

// Functional notes
// RULE1 - two real outputs, further positions phantom
// RULE2 - type codes: null, on/off, pwm, servo
// RULE3 - null type leaves line undriven
// RULE4 - on/off ignores rate and span bit
// RULE5 - rate field selects repetition frequency
// RULE6 - pwm periods 10ms to 10s, 0-100% duty
// RULE7 - servo uses 100 Hz or 50 Hz
// RULE8 - span bit limits servo pulse range
// RULE9 - polarity bit picks pulled or released active
// RULE10 - polarity resets to zero, active low
// RULE11 - tracking flag read-only; clear ignores source
// RULE12 - source field: bit15 enables, sensors 0-3
// RULE13 - no source: software percent drives output
// RULE14 - source selected: output follows scaled sensor
// RULE15 - pwm tracking clamps 0% and 100%
// RULE16 - servo tracking clamps to min and max pulse
// RULE17 - linear interpolation between scale points
module dout_top #(
    parameter int unsigned           NUM_OUT  = 2,
    parameter logic [NUM_OUT-1:0]    TRACK_OK = '1
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                wr_en,
    input  wire logic [1:0]          wr_out,
    input  wire logic [1:0]          wr_reg,
    input  wire logic [15:0]         wr_data,
    input  wire logic [1:0]          rd_out,
    input  wire logic [1:0]          rd_reg,
    output logic      [15:0]         rd_data,
    input  wire logic [3:0][15:0]    sensor_val,
    output logic      [NUM_OUT-1:0]  dout_out,
    output logic      [NUM_OUT-1:0]  dout_oe
);
    import dout_pkg::*;

    typedef struct packed {
        logic [NUM_OUT-1:0][15:0] cfg;
        logic [NUM_OUT-1:0][6:0]  val;
        logic [NUM_OUT-1:0][15:0] lo;
        logic [NUM_OUT-1:0][15:0] hi;
        logic [NUM_OUT-1:0][6:0]  pct;
        logic [7:0]               div;
        logic                     tick;
        logic [15:0]              rd;
    } top_st_t;

    top_st_t q;
    top_st_t d;
    logic [NUM_OUT-1:0] tracking;
    logic [NUM_OUT-1:0][15:0] src;

    // word as software sees it: reserved bits zero, tracking flag from hardware
    function automatic logic [15:0] cfg_view(input logic [15:0] c, input logic t);
        logic [15:0] v;
        v = c & CFG_WMASK;
        v[TRACK_BIT] = t; // RULE11
        return v;
    endfunction : cfg_view

    // source selection per output
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            tracking[i] = TRACK_OK[i] && q.cfg[i][SRC_EN_BIT]; // RULE11 RULE12
            src[i]      = sensor_val[q.cfg[i][SRC_LSB +: 2]]; // RULE12
        end
    end

    // writes, tick divider, percent targets, registered read port
    always_comb begin
        logic [15:0] x;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [22:0] num;
        x   = 16'h0;
        lo  = 16'h0;
        hi  = 16'h0;
        num = 23'h0;
        d   = q;
        d.tick = 1'b0;
        d.div  = q.div + 8'h1;
        if (q.div == 8'(TICK_CYC - 1)) begin
            d.div  = 8'h0;
            d.tick = 1'b1;
        end
        for (int i = 0; i < NUM_OUT; i++) begin
            // positions at or above NUM_OUT match no index and store nothing
            if (wr_en && wr_out == 2'(i)) begin // RULE1
                unique case (wr_reg)
                    REG_CFG:      d.cfg[i] = wr_data & CFG_WMASK;
                    REG_VALUE:    d.val[i] = (wr_data > 16'(PCT_FULL)) ? PCT_FULL
                                                                      : wr_data[6:0];
                    REG_SCALE_LO: d.lo[i]  = wr_data;
                    REG_SCALE_HI: d.hi[i]  = wr_data;
                endcase
            end
            x  = src[i];
            lo = q.lo[i];
            hi = q.hi[i];
            if (!tracking[i]) begin
                d.pct[i] = q.val[i]; // RULE13
            end else if (x <= lo) begin
                d.pct[i] = 7'h0; // RULE14 RULE15 RULE16
            end else if (x >= hi) begin
                d.pct[i] = PCT_FULL; // RULE15 RULE16
            end else begin
                num      = 23'(x - lo) * 23'd100;
                d.pct[i] = 7'(num / 23'(hi - lo)); // RULE17
            end
        end
        d.rd = 16'h0; // phantom positions read zero
        for (int i = 0; i < NUM_OUT; i++) begin
            if (rd_out == 2'(i)) begin
                unique case (rd_reg)
                    REG_CFG:      d.rd = cfg_view(q.cfg[i], TRACK_OK[i]);
                    REG_VALUE:    d.rd = {9'h0, q.val[i]};
                    REG_SCALE_LO: d.rd = q.lo[i];
                    REG_SCALE_HI: d.rd = q.hi[i];
                endcase
            end
        end
    end

    // state register; control word resets to null, active low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                q.cfg[i] <= CFG_RESET; // RULE10
                q.val[i] <= VAL_RESET;
                q.lo[i]  <= LO_RESET;
                q.hi[i]  <= HI_RESET;
                q.pct[i] <= VAL_RESET;
            end
            q.div  <= 8'h0;
            q.tick <= 1'b0;
            q.rd   <= 16'h0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd;

    // one generator per real output
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
        dout_chan_if ch ();
        always_comb begin
            unique case (q.cfg[g][TYPE_LSB +: 4])
                4'h1:    ch.mode = TYPE_ONOFF; // RULE2
                4'h2:    ch.mode = TYPE_PWM;
                4'h3:    ch.mode = TYPE_SERVO;
                default: ch.mode = TYPE_NULL;
            endcase
        end
        assign ch.rate      = q.cfg[g][RATE_LSB +: 3];
        assign ch.span_wide = q.cfg[g][SPAN_BIT];
        assign ch.pol       = q.cfg[g][POL_BIT];
        assign ch.pct       = q.pct[g];
        assign ch.tick      = q.tick;

        dout_pulse_gen u_gen (
            .clk     (clk),
            .rstn    (rstn),
            .ch      (ch),
            .pin_out (dout_out[g]),
            .pin_oe  (dout_oe[g])
        );
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_phantom_zero: assert property (rd_out >= 2'(NUM_OUT) |=> rd_data == 16'h0) // RULE1
        else $error("phantom output read not zero");

    a_flag_readonly: assert property (rd_out == 2'h0 && rd_reg == REG_CFG |=> // RULE11
        rd_data[TRACK_BIT] == TRACK_OK[0] && rd_data[7:6] == 2'h0)
        else $error("tracking flag or reserved bits wrong");

    a_manual_pct: assert property (!tracking[0] |=> q.pct[0] == $past(q.val[0])) // RULE13
        else $error("manual percent not applied");

    a_clamp_low: assert property (tracking[0] && src[0] <= q.lo[0] |=> q.pct[0] == 7'h0) // RULE15
        else $error("low clamp not zero");

    a_clamp_high: assert property (tracking[0] && src[0] > q.lo[0] && src[0] >= q.hi[0] // RULE15
        |=> q.pct[0] == 7'd100)
        else $error("high clamp not full");

    a_value_cap: assert property (wr_en && wr_out == 2'h0 && wr_reg == REG_VALUE // RULE13
        |=> q.val[0] <= 7'd100)
        else $error("percent value above 100");

    a_tick_spacing: assert property (q.tick |=> !q.tick [*8]) // RULE5
        else $error("tick spacing too short");

    a_interp_range: assert property (tracking[0] |=> q.pct[0] <= 7'd100) // RULE17
        else $error("interpolated percent out of range");

endmodule : dout_top

/* test/dout_load_model.sv */
// load model: a pull-up on each open-drain output line
// assumes dout_oe high means the block pulls the line to dout_out (0 V)
`timescale 1ns/100ps
module dout_load_model #(
    parameter int unsigned N = 2
) (
    input  wire logic [N-1:0] dout_out,
    input  wire logic [N-1:0] dout_oe,
    output logic      [N-1:0] line
);
    // a released line floats up to the pull-up level
    assign line = ~dout_oe | dout_out;
endmodule : dout_load_model

/* test/tb_top.sv */
// self-checking bench for the configurable digital outputs
// assumes dout_top with two outputs and a pull-up load on each line
`timescale 1ns/100ps
module tb_top;
    import dout_pkg::*;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             wr_en = 1'b0;
    logic [1:0]       wr_out = 2'h0;
    logic [1:0]       wr_reg = 2'h0;
    logic [15:0]      wr_data = 16'h0000;
    logic [1:0]       rd_out = 2'h0;
    logic [1:0]       rd_reg = 2'h0;
    logic [15:0]      rd_data;
    logic [3:0][15:0] sensor_val = '0;
    logic [1:0]       dout_out;
    logic [1:0]       dout_oe;
    logic [1:0]       line;
    int               fail_count = 0;
    int               samples_checked = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    dout_top #(.NUM_OUT(2), .TRACK_OK(2'h3)) dut (
        .clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_out(wr_out), .wr_reg(wr_reg),
        .wr_data(wr_data), .rd_out(rd_out), .rd_reg(rd_reg), .rd_data(rd_data),
        .sensor_val(sensor_val), .dout_out(dout_out), .dout_oe(dout_oe));

    dout_load_model #(.N(2)) load (.dout_out(dout_out), .dout_oe(dout_oe), .line(line));

    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset

    // one-cycle write strobe
    task automatic wr(input logic [1:0] o, input logic [1:0] r, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_out <= o;
        wr_reg <= r;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data shows the selection of the previous cycle
    task automatic rd(input logic [1:0] o, input logic [1:0] r, input logic [15:0] exp);
        @(posedge clk);
        rd_out <= o;
        rd_reg <= r;
        repeat (2) @(posedge clk);
        #1 chk("rd_data", rd_data, exp);
    endtask : rd

    // bounded wait for a line level
    task automatic wait_line(input int o, input logic lvl);
        int n;
        n = 0;
        while (line[o] !== lvl && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("line level", line[o], lvl);
        if (n == 1000) begin
            fail_count++;
            end_of_test();
        end
    endtask : wait_line

    // width of the first low pulse, in 10 us ticks
    task automatic pulse(input int o, input int exp);
        int n;
        n = 0;
        while (line[o] !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000 && exp != 0) begin
            fail_count++;
            end_of_test();
        end
        n = 0;
        while (line[o] === 1'b0 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        chk("pulse ticks", (n + 125) / 250, exp);
        if (n == 70000) begin
            fail_count++;
            end_of_test();
        end
    endtask : pulse

    // fresh start, scale 100..1100, then measure the first low pulse
    task automatic run(input logic [1:0] o, input logic [15:0] cfg, input logic [15:0] sens,
                       input logic [15:0] val, input int exp);
        do_reset();
        // only the selected sensor carries the reading, the others read zero
        sensor_val <= {48'h0, sens} << (16 * cfg[14:13]);
        wr(o, REG_SCALE_LO, 16'h0064);
        wr(o, REG_SCALE_HI, 16'h044c);
        wr(o, REG_VALUE, val);
        wr(o, REG_CFG, cfg);
        pulse(o, exp);
    endtask : run

    task automatic s_regs();
        do_reset();
        rd(2'h0, REG_CFG, 16'h1000);
        chk("oe after reset", dout_oe, 2'h0);
        wr(2'h0, REG_CFG, 16'hffff);
        rd(2'h0, REG_CFG, 16'hff3f);
        chk("oe type 15", dout_oe, 2'h0);
        wr(2'h2, REG_VALUE, 16'h0032);
        rd(2'h2, REG_VALUE, 16'h0000);
        rd(2'h0, REG_VALUE, 16'h0000);
        wr(2'h0, REG_VALUE, 16'h00c8);
        rd(2'h0, REG_VALUE, 16'h0064);
    endtask : s_regs

    task automatic s_onoff();
        do_reset();
        // full duty pwm on output 0 holds the line pulled for the whole period
        wr(2'h0, REG_VALUE, 16'h0064);
        wr(2'h0, REG_CFG, 16'h0200);
        wait_line(0, 1'b0);
        wr(2'h1, REG_VALUE, 16'h0032);
        wr(2'h1, REG_CFG, 16'h0127);
        wait_line(1, 1'b0);
        wr(2'h1, REG_CFG, 16'h0137);
        wait_line(1, 1'b1);
        wr(2'h1, REG_VALUE, 16'h0000);
        wait_line(1, 1'b0);
    endtask : s_onoff

    task automatic s_pwm();
        run(2'h0, 16'h0200, 16'h0000, 16'h0001, 10);
        run(2'h0, 16'h2200, 16'h01f4, 16'h0002, 20);
    endtask : s_pwm

    task automatic s_track();
        run(2'h0, 16'ha200, 16'h006e, 16'h0032, 10);
        run(2'h0, 16'ha200, 16'h0032, 16'h0032, 0);
        // reading above the upper point gives full duty from the first period
        do_reset();
        sensor_val <= {4{16'h0500}};
        wr(2'h0, REG_SCALE_LO, 16'h0064);
        wr(2'h0, REG_SCALE_HI, 16'h044c);
        wr(2'h0, REG_CFG, 16'ha200);
        wait_line(0, 1'b0);
    endtask : s_track

    task automatic s_servo();
        run(2'h1, 16'h0300, 16'h0000, 16'h0064, 200);
        run(2'h1, 16'he321, 16'h0000, 16'h0064, 50);
    endtask : s_servo

    initial begin
        s_regs();
        s_onoff();
        s_pwm();
        s_track();
        s_servo();
        end_of_test();
    end
endmodule : tb_top
